// >>> urs_defs.vh
// constants and behaviour notes for the usb role select and vbus control block
// Notes on behaviour
// - role pin grounded, no override: host
// - role pin floating high: peripheral role
// - override bit 0 selects host
// - override bit 1 selects peripheral
// - dual role mode follows live pin level
// - host: drive vbus, then await sense
// - no vbus within 100ms: error event
// - host with valid vbus: await connect
// - peripheral runs only while vbus valid
// - charge enable set until software clears
// - host masters bus, peripheral only responds
// - each port holds own role config
`ifndef URS_DEFS_VH
`define URS_DEFS_VH
`define URS_CLK_HZ 40000000
`define URS_VBUS_TIMEOUT_MS 100
// 100 ms at 40 MHz, sized to the 23 bit wait timer
`define URS_VBUS_TIMEOUT_CYC 23'h3D0900
// edges the role pin needs to cross its synchroniser
`define URS_SYNC_SETTLE 2'h2
`define URS_CNT_W 23
`define URS_ST_W 3
`endif

// >>> urs_sync2.v
// two flop synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module urs_sync2 (
   input wire clock,
   input wire rst_n,
   input wire rst_value,
   input wire din,
   output wire dout
);
   reg stage1;
   reg stage2;
   // first flop read only by the second; reset value is a constant per instance via xor with rst_value around both flops
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         stage1 <= 1'b0;
         stage2 <= 1'b0;
      end else begin
         stage1 <= din ^ rst_value;
         stage2 <= stage1;
      end
   end
   assign dout = stage2 ^ rst_value;
endmodule
`default_nettype wire

// >>> urs_port.v
// role selection and vbus supervision for one dual-role usb port
`timescale 1ns/1ps
`default_nettype none
`include "urs_defs.vh"
// role policy: an enabled override beats the pin; without dual role mode or
// an override the role is decided once after reset and pin moves are ignored
// limitation: a vbus error stays until the role is decided again, even if the
// supply comes up late, so software sees every failed start
// the supply switch stays on in the error state so the rail can be measured
module urs_port #(
   parameter [22:0] VBUS_TIMEOUT_CYC = `URS_VBUS_TIMEOUT_CYC
) (
   input wire clock,
   input wire rst_n,
   input wire role_select_pin,
   input wire vbus_sense_in,
   input wire override_en,
   input wire id_override_bit,
   input wire dual_role_mode,
   input wire charger_detect,
   input wire charger_disable,
   input wire device_connect,
   output reg vbus_drive_out,
   output reg charge_enable,
   output reg is_host,
   output reg host_ready,
   output reg periph_active,
   output reg vbus_error,
   output wire bus_master,
   output reg [2:0] role_state
);
   ////////////////////////////////////////////////////////////////////
   // role states
   // idle decides the role once the synchronisers have settled
   // host wait drives the supply and times the sense input
   // host up and host conn follow the attached device
   // host err is sticky until the role is decided again
   // peripheral wait and run follow the sensed supply only
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_HOST_WAIT = 3'h1;
   localparam [2:0] ST_HOST_UP = 3'h2;
   localparam [2:0] ST_HOST_CONN = 3'h3;
   localparam [2:0] ST_HOST_ERR = 3'h4;
   localparam [2:0] ST_PERIPH_WAIT = 3'h5;
   localparam [2:0] ST_PERIPH_RUN = 3'h6;

   wire id_sync;
   wire vbus_sync;
   wire conn_sync;
   reg role_latched;
   reg [2:0] next_state;
   reg [22:0] vbus_timer;
   wire want_host;
   wire timed_out;
   reg [1:0] settle;
   reg [1:0] next_settle;
   wire settled;
   reg next_role_latched;
   reg [22:0] next_vbus_timer;
   reg next_vbus_drive_out;
   reg next_is_host;
   reg next_host_ready;
   reg next_periph_active;
   reg next_vbus_error;
   reg next_charge_enable;

   ////////////////////////////////////////////////////////////////////
   // input synchronisers; role pin idles high like a pulled-up line
   urs_sync2 u_sync_id (
      .clock(clock),
      .rst_n(rst_n),
      .rst_value(1'b1),
      .din(role_select_pin),
      .dout(id_sync)
   );
   urs_sync2 u_sync_vbus (
      .clock(clock),
      .rst_n(rst_n),
      .rst_value(1'b0),
      .din(vbus_sense_in),
      .dout(vbus_sync)
   );
   urs_sync2 u_sync_conn (
      .clock(clock),
      .rst_n(rst_n),
      .rst_value(1'b0),
      .din(device_connect),
      .dout(conn_sync)
   );

   ////////////////////////////////////////////////////////////////////
   // role decode: override wins, else live pin (0 host, 1 peripheral)
   function role_is_host;
      input ovr_en;
      input ovr_bit;
      input pin;
      begin
         if (ovr_en) begin
            role_is_host = ~ovr_bit;
         end else begin
            role_is_host = ~pin;
         end
      end
   endfunction

   // host side states share the supply switch and the master role
   function state_is_host;
      input [2:0] st;
      begin
         case (st)
            ST_HOST_WAIT, ST_HOST_UP, ST_HOST_CONN, ST_HOST_ERR: begin
               state_is_host = 1'h1;
            end
            default: begin
               state_is_host = 1'h0;
            end
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // settle count: the role pin needs two edges through its synchroniser;
   // deciding earlier would latch the synchroniser's reset value instead
   assign settled = (settle == `URS_SYNC_SETTLE);

   always @* begin
      next_settle = settle;
      if (!settled) begin
         next_settle = settle + 2'h1;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         settle <= 2'h0;
      end else begin
         settle <= next_settle;
      end
   end

   assign want_host = role_is_host(override_en, id_override_bit, id_sync);
   assign timed_out = (vbus_timer >= VBUS_TIMEOUT_CYC - 23'h000001);
   // host issues traffic, peripheral only answers
   assign bus_master = is_host;

   ////////////////////////////////////////////////////////////////////
   // role latch: without dual role mode the role is taken once per idle
   always @* begin
      next_role_latched = role_latched;
      if (role_state == ST_IDLE) begin
         next_role_latched = want_host;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         role_latched <= 1'h0;
      end else begin
         role_latched <= next_role_latched;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // next state; a role change restarts through idle
   always @* begin
      next_state = role_state;
      case (role_state)
         ST_IDLE: begin
            // wait until the synchronised pin shows its real level
            if (!settled) begin
               next_state = ST_IDLE;
            end else if (want_host) begin
               next_state = ST_HOST_WAIT;
            end else begin
               next_state = ST_PERIPH_WAIT;
            end
         end
         ST_HOST_WAIT: begin
            if (vbus_sync) begin
               next_state = ST_HOST_UP;
            end else if (timed_out) begin
               next_state = ST_HOST_ERR;
            end
         end
         ST_HOST_UP: begin
            if (conn_sync) begin
               next_state = ST_HOST_CONN;
            end
         end
         ST_HOST_CONN: begin
            if (!conn_sync) begin
               next_state = ST_HOST_UP;
            end
         end
         ST_HOST_ERR: begin
            next_state = ST_HOST_ERR;
         end
         ST_PERIPH_WAIT: begin
            if (vbus_sync) begin
               next_state = ST_PERIPH_RUN;
            end
         end
         ST_PERIPH_RUN: begin
            if (!vbus_sync) begin
               next_state = ST_PERIPH_WAIT;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
      // dual role follows the pin live; otherwise only an override change re-decides
      if (role_state != ST_IDLE && want_host != role_latched) begin
         if (dual_role_mode || override_en) begin
            next_state = ST_IDLE;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // vbus wait timer: counts only while host wait holds, so any exit rearms it
   always @* begin
      if (role_state == ST_HOST_WAIT && next_state == ST_HOST_WAIT) begin
         next_vbus_timer = vbus_timer + 23'h000001;
      end else begin
         next_vbus_timer = 23'h000000;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // state register and vbus wait timer
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         role_state <= ST_IDLE;
         vbus_timer <= 23'h000000;
      end else begin
         role_state <= next_state;
         vbus_timer <= next_vbus_timer;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // output values come from the state being entered, so outputs move with it
   always @* begin
      // supply stays on through error so software can inspect the rail
      next_vbus_drive_out = state_is_host(next_state);
      next_is_host = state_is_host(next_state);
      next_host_ready = (next_state == ST_HOST_UP) || (next_state == ST_HOST_CONN);
      next_periph_active = (next_state == ST_PERIPH_RUN);
   end

   ////////////////////////////////////////////////////////////////////
   // role outputs; every port instance keeps its own, so two ports differ freely
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vbus_drive_out <= 1'h0;
         is_host <= 1'h0;
         host_ready <= 1'h0;
         periph_active <= 1'h0;
      end else begin
         vbus_drive_out <= next_vbus_drive_out;
         is_host <= next_is_host;
         host_ready <= next_host_ready;
         periph_active <= next_periph_active;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // error flag: sticky level, cleared only by leaving the role through idle
   always @* begin
      next_vbus_error = vbus_error;
      if (role_state == ST_HOST_WAIT && next_state == ST_HOST_ERR) begin
         next_vbus_error = 1'h1;
      end else if (next_state == ST_IDLE) begin
         next_vbus_error = 1'h0;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vbus_error <= 1'h0;
      end else begin
         vbus_error <= next_vbus_error;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // charge enable: detect sets, software disable clears, set wins together
   always @* begin
      next_charge_enable = charge_enable;
      if (charger_detect) begin
         next_charge_enable = 1'h1;
      end else if (charger_disable) begin
         next_charge_enable = 1'h0;
      end
   end

   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         charge_enable <= 1'h0;
      end else begin
         charge_enable <= next_charge_enable;
      end
   end
endmodule
`default_nettype wire

// >>> urs_chk.sv
// assertion checker for the role select port
`timescale 1ns/1ps
`default_nettype none
module urs_chk #(
   parameter [22:0] VBUS_TIMEOUT_CYC = 23'h000014
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic vbus_sense_in,
   input wire logic charger_detect,
   input wire logic charger_disable,
   input wire logic vbus_drive_out,
   input wire logic charge_enable,
   input wire logic is_host,
   input wire logic host_ready,
   input wire logic periph_active,
   input wire logic vbus_error,
   input wire logic bus_master,
   input wire logic [2:0] role_state
);
   int cnt;
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   // dwell in host wait, so the timeout figure is checked exactly
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n)
         cnt <= 0;
      else
         cnt <= (role_state == 3'h1) ? cnt + 1 : 0;
   end
   a_drive_in_host: assert property (role_state inside {[3'h1:3'h4]} |-> vbus_drive_out)
      else $error("drive low");
   a_master_follows_role: assert property (bus_master == (role_state inside {[3'h1:3'h4]}))
      else $error("master mismatch");
   a_wait_bound: assert property (role_state == 3'h1 |-> cnt < VBUS_TIMEOUT_CYC)
      else $error("wait too long");
   a_error_on_time: assert property ($rose(vbus_error) |-> cnt == VBUS_TIMEOUT_CYC && role_state == 3'h4)
      else $error("error off time");
   a_vbus_moves_on: assert property (role_state == 3'h1 && vbus_sense_in |-> ##[1:4] role_state != 3'h1)
      else $error("stuck in wait");
   a_ready_when_up: assert property (role_state == 3'h2 |-> host_ready && is_host)
      else $error("not ready");
   a_periph_needs_vbus: assert property ((!vbus_sense_in) [*4] |-> !periph_active)
      else $error("runs without vbus");
   a_charge_set: assert property (charger_detect |=> charge_enable)
      else $error("charge not set");
   a_charge_hold: assert property (charge_enable && !charger_disable |=> charge_enable)
      else $error("charge lost");
   c_host_conn: cover property (role_state == 3'h3);
   c_error: cover property ($rose(vbus_error));
   c_periph: cover property (periph_active);
endmodule
`default_nettype wire

// >>> urs_remote.sv
// far side model: 5V switch plus remote host or device
`timescale 1ns/1ps
`default_nettype none
module urs_remote (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic vbus_drive_out,
   input wire logic switch_ok,
   input wire logic remote_vbus,
   input wire logic attach,
   output wire logic vbus_sense_in,
   output wire logic device_connect
);
   logic [1:0] ramp;
   // switch output takes a few cycles to rise; a faulty switch never does
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n || !vbus_drive_out || !switch_ok)
         ramp <= 2'h0;
      else if (ramp != 2'h3)
         ramp <= ramp + 2'h1;
   end
   assign vbus_sense_in = (ramp == 2'h3) || remote_vbus;
   assign device_connect = attach;
endmodule
`default_nettype wire

// >>> tb_urs_port.sv
// testbench for the role select and vbus port
`timescale 1ns/1ps
`default_nettype none
module tb_urs_port;
   logic clock = 0, rst_n = 0, pin = 0, ovr_en = 0, ovr_bit = 0, dual = 0;
   logic det = 0, dis = 0, sw_ok = 1, rhost = 0, attach = 0;
   wire vbus, conn, drive, chg, host, rdy, per, err, master, host2;
   wire [2:0] st;
   int error_cnt = 0, total_checks = 0, cyc = 0;
   urs_port #(.VBUS_TIMEOUT_CYC(23'h000014)) i_dut (.clock(clock), .rst_n(rst_n), .role_select_pin(pin),
      .vbus_sense_in(vbus), .override_en(ovr_en), .id_override_bit(ovr_bit), .dual_role_mode(dual),
      .charger_detect(det), .charger_disable(dis), .device_connect(conn), .vbus_drive_out(drive),
      .charge_enable(chg), .is_host(host), .host_ready(rdy), .periph_active(per), .vbus_error(err),
      .bus_master(master), .role_state(st));
   urs_remote i_far (.clock(clock), .rst_n(rst_n), .vbus_drive_out(drive), .switch_ok(sw_ok),
      .remote_vbus(rhost), .attach(attach), .vbus_sense_in(vbus), .device_connect(conn));
   // second port on the inverted pin: roles differ while no override applies
   urs_port #(.VBUS_TIMEOUT_CYC(23'h000014)) i_dut2 (.clock(clock), .rst_n(rst_n), .role_select_pin(~pin),
      .vbus_sense_in(rhost), .override_en(ovr_en), .id_override_bit(ovr_bit), .dual_role_mode(dual),
      .charger_detect(det), .charger_disable(dis), .device_connect(attach), .vbus_drive_out(),
      .charge_enable(), .is_host(host2), .host_ready(), .periph_active(), .vbus_error(),
      .bus_master(), .role_state());
   always #12.5 clock = ~clock;
   task stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // run is about 130 cycles; a hang is cut well beyond that
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 600) begin
         error_cnt = error_cnt + 1;
         stop_test;
      end
   end
   task step(input int n);
      repeat (n) @(posedge clock);
      #2;
   endtask
   task chk(input logic [4:0] got, input logic [4:0] exp);
      total_checks = total_checks + 1;
      if (got !== exp) begin
         error_cnt = error_cnt + 1;
         $display("FAIL %0t got %0h want %0h", $time, got, exp);
      end
   endtask
   // main sequence: roles, vbus supervision, charger
   initial begin
      step(7);
      chk({st, drive}, 4'h0);
      @(posedge clock) rst_n <= 1;
      step(14);
      chk({host, master, rdy}, 3'h7);
      chk({drive, err, per}, 3'h4);
      chk({host, host2}, 2'h2);
      @(posedge clock) attach <= 1;
      step(5);
      chk(st, 3'h3);
      @(posedge clock) {ovr_en, ovr_bit, rhost} <= 3'h7;
      step(10);
      chk({per, host, drive}, 3'h4);
      chk(st, 3'h6);
      @(posedge clock) rhost <= 0;
      step(5);
      chk({per, st}, 4'h5);
      @(posedge clock) {ovr_bit, sw_ok} <= 2'h0;
      step(6);
      chk({st, err}, 4'h2);
      step(25);
      chk({st, err}, 4'h9);
      @(posedge clock) sw_ok <= 1;
      step(10);
      chk({st, err}, 4'h9);
      @(posedge clock) {ovr_en, dual, pin} <= 3'h3;
      step(10);
      chk({host, err, st}, 5'h05);
      @(posedge clock) pin <= 0;
      step(14);
      chk({host, st}, 4'hB);
      @(posedge clock) det <= 1;
      @(posedge clock) det <= 0;
      step(4);
      chk(chg, 1'h1);
      @(posedge clock) dis <= 1;
      @(posedge clock) det <= 1;
      step(2);
      chk(chg, 1'h1);
      @(posedge clock) det <= 0;
      step(3);
      chk(chg, 1'h0);
      stop_test;
   end
endmodule
bind urs_port urs_chk #(.VBUS_TIMEOUT_CYC(VBUS_TIMEOUT_CYC)) i_chk (.clock(clock), .rst_n(rst_n),
   .vbus_sense_in(vbus_sense_in), .charger_detect(charger_detect), .charger_disable(charger_disable),
   .vbus_drive_out(vbus_drive_out), .charge_enable(charge_enable), .is_host(is_host), .host_ready(host_ready),
   .periph_active(periph_active), .vbus_error(vbus_error), .bus_master(bus_master), .role_state(role_state));
`default_nettype wire
